// ### rtl/core_seq_pkg.sv
// constants, types and register map of the fetch and sequencing core
package core_seq_pkg;

  localparam int          PC_W             = 21;
  localparam int          DADDR_W          = 12;
  localparam int          BANK_W           = 4;
  localparam int          IWORD_W          = 16;
  localparam logic [20:0] PC_STEP          = 21'h000002;
  localparam logic [20:0] PC_RESET         = 21'h000000;

  // register byte addresses on the bus
  localparam logic [7:0]  OFS_PC_LOW       = 8'h00;
  localparam logic [7:0]  OFS_PC_HIGH_LAT  = 8'h04;
  localparam logic [7:0]  OFS_PC_UPPER_LAT = 8'h08;
  localparam logic [7:0]  OFS_BANK_SELECT  = 8'h0C;
  localparam logic [7:0]  OFS_INDIRECT     = 8'h10;
  localparam logic [7:0]  OFS_WORK         = 8'h14;
  localparam logic [7:0]  OFS_CONTROL      = 8'h18;
  localparam logic [7:0]  OFS_STATUS       = 8'h1C;

  localparam logic [7:0]  LATCH_RESET      = 8'h00;
  localparam logic [3:0]  BANK_RESET       = 4'h0;
  localparam logic [11:0] INDIRECT_RESET   = 12'h000;
  localparam logic [7:0]  WORK_RESET       = 8'h00;
  localparam logic        RUN_RESET        = 1'b1;
  localparam int          CTRL_RUN_BIT     = 0;
  localparam int          STAT_VALID_BIT   = 16;
  localparam int          STAT_PHASE_LSB   = 17;

  // data memory map
  localparam logic [11:0] SFR_BASE         = 12'hF60;
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [3:0]  ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0]  ACCESS_LOW_BANK  = 4'h0;
  localparam logic [11:0] INDIRECT_OPERAND = 12'hFEF;
  localparam logic [11:0] GPR_SIZE_DEF     = 12'h300;

  // instruction encodings
  localparam logic [7:0]  OP_GOTO          = 8'hEF;
  localparam logic [4:0]  OP_BRANCH        = 5'h1A;
  localparam logic [5:0]  OP_INC_FILE      = 6'h0A;
  localparam logic [6:0]  OP_TEST_SKIP     = 7'h33;
  localparam logic [3:0]  SECOND_WORD_TAG  = 4'hF;
  localparam logic [15:0] NO_OPERATION     = 16'h0000;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } phase_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;

endpackage

// ### rtl/core_sequencer.sv
// program counter, four-phase clock, fetch/execute pipeline and banking
//
// Summary of operation
// - program counter is 21 bits; its low byte is readable and writable
// - the bus changes counter bits 15..8 only through the high latch
// - the bus changes counter bits 20..16 only through the upper latch
// - writing the low byte loads both latches into the counter
// - reading the low byte copies counter upper bytes into the latches
// - counter bit 0 is always zero; sequential step is 2
// - jumps and branches load the counter without using the latches
// - input clock divided by four gives four phases per cycle
// - counter increments in phase one; instruction latched in phase four
// - execute reads operand in phase two, writes destination in four
// - fetch of next overlaps execute of current instruction
// - counter-changing instruction flushes the fetched word, two cycles
// - instructions are 2 or 4 bytes, low byte at even address
// - absolute jump writes embedded word address into counter bits 20..1
// - relative branch offset counts single-word instructions
// - second word has top 4 bits set and 12 data bits
// - a second word executed alone behaves as no operation
// - data addresses are 12 bits, 4096 bytes of space
// - 16 banks of 256 bytes; bank select keeps only 4 bits
// - special registers span FFFh..F60h; unimplemented reads give zero
// - indirect pointer holds a full 12-bit address, ignores banking
// - access region of bank 0 and bank 15 ignores bank select
// - general purpose data memory is never initialised by the core
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module core_sequencer
  import core_seq_pkg::*;
#(
  parameter logic [11:0] GPR_SIZE = GPR_SIZE_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire apb_req_t    apb_req,
  output apb_rsp_t         apb_rsp,
  output logic [20:0]      prog_addr,
  input  wire logic [15:0] prog_data,
  output logic [11:0]      data_addr,
  output logic             data_rd,
  output logic             data_wr,
  output logic [7:0]       data_wdata,
  input  wire logic [7:0]  data_rdata,
  output logic [3:0]       phase_clocks
);

  typedef struct packed {
    phase_t      q;
    logic [3:0]  phase_clocks;
    logic [20:0] pc;
    logic [20:0] fetch_addr;
    logic [15:0] ir;
    logic        ir_valid;
    logic        flush_pending;
    logic [7:0]  pc_high_latch;
    logic [7:0]  pc_upper_latch;
    logic [3:0]  bank_select;
    logic [11:0] indirect_pointer;
    logic [7:0]  work;
    logic        run;
    logic [7:0]  operand;
    logic [11:0] data_addr;
    logic        data_rd;
    logic        data_wr;
    logic [7:0]  data_wdata;
    apb_rsp_t    rsp;
  } state_t;

  state_t s;
  state_t next_s;

  // direct file address to full data address
  function automatic logic [11:0] file_addr(
    input logic [7:0]  f,
    input logic        banked,
    input logic [3:0]  bank,
    input logic [11:0] pointer
  );
    logic [11:0] a;
    if (banked) begin
      a = {bank, f};
    end else if (f < ACCESS_SPLIT) begin
      a = {ACCESS_LOW_BANK, f};
    end else begin
      a = {ACCESS_HIGH_BANK, f};
    end
    if (a == INDIRECT_OPERAND) begin
      a = pointer;
    end
    return a;
  endfunction

  // locations in the general purpose space or among the special registers
  function automatic logic implemented(input logic [11:0] a);
    return (a < GPR_SIZE) || (a >= SFR_BASE);
  endfunction

  function automatic logic [3:0] phase_onehot(input phase_t q);
    return 4'h1 << q;
  endfunction

  // byte registers answer in the low lane with the rest of the word zero
  function automatic logic [31:0] byte_word(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  function automatic phase_t next_phase(input phase_t q);
    phase_t n;
    unique case (q)
      Q1: n = Q2;
      Q2: n = Q3;
      Q3: n = Q4;
      Q4: n = Q1;
    endcase
    return n;
  endfunction

  logic        advance;
  logic        live;
  logic        is_skip;
  logic        is_goto;
  logic        is_branch;
  logic        is_inc;
  logic        is_test;
  logic        uses_data;
  logic [11:0] ea;
  logic        ea_ok;
  logic [20:0] branch_target;
  logic [20:0] goto_target;

  always_comb begin
    // a cleared run bit stops the phases only once they are back at Q1
    advance   = s.run || (s.q != Q1);
    // a second word met on its own decodes as nothing at all
    live      = s.ir_valid && (s.ir[15:12] != SECOND_WORD_TAG);
    is_goto   = live && (s.ir[15:8] == OP_GOTO);
    is_branch = live && (s.ir[15:11] == OP_BRANCH);
    is_inc    = live && (s.ir[15:10] == OP_INC_FILE);
    is_test   = live && (s.ir[15:9] == OP_TEST_SKIP);
    is_skip   = is_test && (s.operand == 8'h00);
    uses_data = is_inc || is_test;
    ea        = file_addr(s.ir[7:0], s.ir[8], s.bank_select,
                          s.indirect_pointer);
    ea_ok     = implemented(ea);
    // offset is in words, so it is doubled onto the fetch address
    branch_target = s.fetch_addr +
                    {{9{s.ir[10]}}, s.ir[10:0], 1'b0};
    goto_target   = {prog_data[11:0], s.ir[7:0], 1'b0};
  end

  always_comb begin
    next_s = s;
    next_s.rsp.pready  = 1'b0;
    next_s.rsp.pslverr = 1'b0;

    if (advance) begin
      next_s.q = next_phase(s.q);
    end
    next_s.phase_clocks = phase_onehot(next_s.q);

    if (advance) begin
      unique case (s.q)
        Q1: begin
          // fetch of the next word runs while the current one executes
          next_s.fetch_addr = s.pc;
          next_s.pc = s.pc + PC_STEP;
          if (uses_data && ea_ok) begin
            next_s.data_addr = ea;
            next_s.data_rd   = 1'b1;
          end
        end
        Q2: begin
          next_s.data_rd = 1'b0;
        end
        Q3: begin
          if (uses_data) begin
            // unimplemented locations read as zero and take no write
            next_s.operand = ea_ok ? data_rdata : 8'h00;
            if (is_inc) begin
              if (s.ir[9] && ea_ok) begin
                next_s.data_wr    = 1'b1;
                next_s.data_wdata = data_rdata + 8'h01;
              end else if (!s.ir[9]) begin
                next_s.work = (ea_ok ? data_rdata : 8'h00) + 8'h01;
              end
            end
          end
        end
        Q4: begin
          next_s.data_wr  = 1'b0;
          next_s.ir       = prog_data;
          next_s.ir_valid = 1'b1;
          next_s.flush_pending = 1'b0;
          if (is_goto) begin
            next_s.pc       = goto_target;
            next_s.ir       = NO_OPERATION;
            next_s.ir_valid = 1'b0;
          end else if (is_branch) begin
            next_s.pc       = branch_target;
            next_s.ir       = NO_OPERATION;
            next_s.ir_valid = 1'b0;
          end else if (is_skip || s.flush_pending) begin
            next_s.ir       = NO_OPERATION;
            next_s.ir_valid = 1'b0;
          end
        end
      endcase
    end

    // register bus: answer one cycle into the access phase
    if (apb_req.psel && apb_req.penable && !s.rsp.pready) begin
      next_s.rsp.pready = 1'b1;
      next_s.rsp.prdata = 32'h00000000;
      unique case (apb_req.paddr)
        OFS_PC_LOW: begin
          if (apb_req.pwrite) begin
            next_s.pc = {s.pc_upper_latch[4:0], s.pc_high_latch,
                         apb_req.pwdata[7:1], 1'b0};
            // a core stopped at Q1 has no stale fetch in flight
            next_s.flush_pending = advance && (s.q != Q4);
            next_s.ir       = NO_OPERATION;
            next_s.ir_valid = 1'b0;
          end else begin
            next_s.rsp.prdata  = byte_word({s.pc[7:1], 1'b0});
            next_s.pc_high_latch  = s.pc[15:8];
            next_s.pc_upper_latch = {3'b000, s.pc[20:16]};
          end
        end
        OFS_PC_HIGH_LAT: begin
          if (apb_req.pwrite) begin
            next_s.pc_high_latch = apb_req.pwdata[7:0];
          end
          next_s.rsp.prdata = byte_word(s.pc_high_latch);
        end
        OFS_PC_UPPER_LAT: begin
          if (apb_req.pwrite) begin
            next_s.pc_upper_latch = apb_req.pwdata[7:0];
          end
          next_s.rsp.prdata = byte_word(s.pc_upper_latch);
        end
        OFS_BANK_SELECT: begin
          if (apb_req.pwrite) begin
            next_s.bank_select = apb_req.pwdata[3:0];
          end
          next_s.rsp.prdata = {28'h0000000, s.bank_select};
        end
        OFS_INDIRECT: begin
          if (apb_req.pwrite) begin
            next_s.indirect_pointer = apb_req.pwdata[11:0];
          end
          next_s.rsp.prdata = {20'h00000, s.indirect_pointer};
        end
        OFS_WORK: begin
          if (apb_req.pwrite) begin
            next_s.work = apb_req.pwdata[7:0];
          end
          next_s.rsp.prdata = byte_word(s.work);
        end
        OFS_CONTROL: begin
          if (apb_req.pwrite) begin
            next_s.run = apb_req.pwdata[CTRL_RUN_BIT];
          end
          next_s.rsp.prdata = {31'h0, s.run};
        end
        OFS_STATUS: begin
          next_s.rsp.prdata[15:0] = s.ir;
          next_s.rsp.prdata[STAT_VALID_BIT] = s.ir_valid;
          next_s.rsp.prdata[STAT_PHASE_LSB +: 2] = s.q;
        end
        default: begin
          next_s.rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  // data memory contents are outside and never cleared here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s.q                <= Q1;
      s.phase_clocks     <= 4'h1;
      s.pc               <= PC_RESET;
      s.fetch_addr       <= PC_RESET;
      s.ir               <= NO_OPERATION;
      s.ir_valid         <= 1'b0;
      s.flush_pending    <= 1'b0;
      s.pc_high_latch    <= LATCH_RESET;
      s.pc_upper_latch   <= LATCH_RESET;
      s.bank_select      <= BANK_RESET;
      s.indirect_pointer <= INDIRECT_RESET;
      s.work             <= WORK_RESET;
      s.run              <= RUN_RESET;
      s.operand          <= 8'h00;
      s.data_addr        <= 12'h000;
      s.data_rd          <= 1'b0;
      s.data_wr          <= 1'b0;
      s.data_wdata       <= 8'h00;
      s.rsp              <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp      = s.rsp;
  assign prog_addr    = s.fetch_addr;
  assign data_addr    = s.data_addr;
  assign data_rd      = s.data_rd;
  assign data_wr      = s.data_wr;
  assign data_wdata   = s.data_wdata;
  assign phase_clocks = s.phase_clocks;

endmodule

// ### tb/core_sequencer_monitor.sv
// port-level checker for the fetch and sequencing core
`timescale 1ns/100ps
module core_sequencer_monitor
  import core_seq_pkg::*;
#(
  parameter logic [11:0] GPR_SIZE = GPR_SIZE_DEF
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire apb_req_t    apb_req,
  input wire apb_rsp_t    apb_rsp,
  input wire logic [20:0] prog_addr,
  input wire logic [15:0] prog_data,
  input wire logic [11:0] data_addr,
  input wire logic        data_rd,
  input wire logic        data_wr,
  input wire logic [7:0]  data_wdata,
  input wire logic [7:0]  data_rdata,
  input wire logic [3:0]  phase_clocks
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  phase_one_hot_a: assert property ($onehot(phase_clocks))
    else $error("phase clocks not one-hot");
  phase_order_a: assert property (phase_clocks[1] |=>
    phase_clocks[2] ##1 phase_clocks[3] ##1 phase_clocks[0])
    else $error("phase sequence broken");
  pc_even_a: assert property (prog_addr[0] == 1'b0)
    else $error("fetch address odd");
  fetch_hold_a: assert property ((phase_clocks[2] || phase_clocks[3])
    |-> $stable(prog_addr)) else $error("fetch address moved late");
  read_phase_a: assert property (data_rd |-> phase_clocks[1])
    else $error("data read outside second phase");
  write_phase_a: assert property (data_wr |-> phase_clocks[3]
    && $past(data_rd, 2) && $stable(data_addr))
    else $error("data write outside fourth phase");
  write_data_a: assert property (data_wr |->
    data_wdata == $past(data_rdata) + 8'h01) else $error("bad write data");
  unimpl_gap_a: assert property ((data_rd || data_wr) |->
    (data_addr < GPR_SIZE || data_addr >= SFR_BASE))
    else $error("access to unimplemented data space");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  ready_time_a: assert property ($rose(apb_req.psel && apb_req.penable)
    |=> apb_rsp.pready) else $error("ready late");
endmodule

bind core_sequencer core_sequencer_monitor #(.GPR_SIZE(GPR_SIZE)) mon (
  .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
  .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
  .data_rdata(data_rdata), .phase_clocks(phase_clocks));

// ### tb/prog_data_mem.sv
// program memory holding the test program, and byte-wide data memory
`timescale 1ns/100ps
module prog_data_mem
  import core_seq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [20:0] prog_addr,
  output logic [15:0]      prog_data,
  input  wire logic [11:0] data_addr,
  input  wire logic        data_rd,
  input  wire logic        data_wr,
  input  wire logic [7:0]  data_wdata,
  output logic [7:0]       data_rdata
);
  logic [7:0] ram [4096];
  always_comb begin
    case (prog_addr)
      21'h000000: prog_data = 16'h2A10;
      21'h000002: prog_data = 16'h6620;
      21'h000004: prog_data = 16'h2A10;
      21'h000006: prog_data = 16'hF010;
      21'h000008: prog_data = 16'hEF08;
      21'h00000A: prog_data = 16'hF000;
      21'h00000C: prog_data = 16'h2A10;
      21'h00000E: prog_data = 16'h2A10;
      21'h000010: prog_data = 16'hD7FF;
      21'h000012: prog_data = 16'h2A10;
      21'h010000: prog_data = 16'h2A70;
      21'h010002: prog_data = 16'h2AEF;
      21'h010004: prog_data = 16'h2B22;
      21'h010006: prog_data = 16'h2810;
      21'h010008: prog_data = 16'hD7FF;
      default:    prog_data = NO_OPERATION;
    endcase
  end
  initial begin
    for (int i = 0; i < 4096; i++) ram[i] = 8'h00;
    data_rdata = 8'h00;
  end
  // outside a read the bus shows a changing pattern, not the last byte
  always @(posedge clk) begin
    if (data_wr) ram[data_addr] <= data_wdata;
    data_rdata <= data_rd ? ram[data_addr] : ~data_rdata;
  end
endmodule

// ### tb/core_sequencer_tb.sv
// self-checking bench for the fetch and sequencing core
`timescale 1ns/100ps
module core_sequencer_tb
  import core_seq_pkg::*;
;
  logic        clk;
  logic        rst;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [20:0] prog_addr;
  logic [15:0] prog_data;
  logic [11:0] data_addr;
  logic        data_rd;
  logic        data_wr;
  logic [7:0]  data_wdata;
  logic [7:0]  data_rdata;
  logic [3:0]  phase_clocks;
  logic [31:0] fails;
  logic [31:0] checks_done;
  logic [31:0] writes;
  logic [19:0] last_wr;

  core_sequencer uut (.clk(clk), .rst(rst), .apb_req(req), .apb_rsp(rsp),
    .prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr),
    .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
    .data_rdata(data_rdata), .phase_clocks(phase_clocks));
  prog_data_mem mem (.clk(clk), .prog_addr(prog_addr),
    .prog_data(prog_data), .data_addr(data_addr), .data_rd(data_rd),
    .data_wr(data_wr), .data_wdata(data_wdata), .data_rdata(data_rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (data_wr === 1'b1) begin
      writes  <= writes + 32'h1;
      last_wr <= {data_addr, data_wdata};
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 32'h1;
    if (seen !== exp) begin
      fails = fails + 32'h1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 32'h0 && checks_done != 32'h0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [32:0] r);
    int n;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    // pready is read as it stood at each rising edge
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      fails = fails + 32'h1;
      conclude();
    end else begin
      r = {rsp.pslverr, rsp.prdata};
      req <= '0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic err);
    logic [32:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r[31:0], e);
    check({31'h0, r[32]}, {31'h0, err});
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    fails = 32'h0;
    checks_done = 32'h0;
    writes = 32'h0;
    last_wr = 20'h0;
    repeat (20) @(posedge clk);
    check({11'h0, prog_addr}, 32'h0);
    rst <= 1'b0;
    rd(OFS_PC_HIGH_LAT, 32'h0, 1'b0);
    rd(OFS_BANK_SELECT, 32'h0, 1'b0);
    repeat (300) @(posedge clk);
    check(writes, 32'h1);
    check({12'h0, last_wr}, 32'h00001001);
    repeat (8) begin
      @(negedge clk);
      check({11'h0, prog_addr[20:2], 2'b00}, 32'h10);
    end
    wr(OFS_CONTROL, 32'h0);
    wr(OFS_PC_HIGH_LAT, 32'h12);
    wr(OFS_PC_UPPER_LAT, 32'h1F);
    wr(OFS_PC_LOW, 32'h35);
    rd(OFS_PC_LOW, 32'h34, 1'b0);
    wr(OFS_PC_HIGH_LAT, 32'h0);
    wr(OFS_PC_UPPER_LAT, 32'h0);
    rd(OFS_PC_LOW, 32'h34, 1'b0);
    rd(OFS_PC_HIGH_LAT, 32'h12, 1'b0);
    rd(OFS_PC_UPPER_LAT, 32'h1F, 1'b0);
    wr(OFS_CONTROL, 32'h1);
    for (int i = 0; i < 8 && phase_clocks[2] !== 1'b1; i++) @(negedge clk);
    check({11'h0, prog_addr}, 32'h001F1234);
    wr(OFS_BANK_SELECT, 32'hFF);
    rd(OFS_BANK_SELECT, 32'h0F, 1'b0);
    wr(OFS_INDIRECT, 32'hFFFF);
    rd(OFS_INDIRECT, 32'hFFF, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(OFS_PC_HIGH_LAT, 32'h0);
    wr(OFS_PC_UPPER_LAT, 32'h1);
    wr(OFS_PC_LOW, 32'h0);
    repeat (60) @(posedge clk);
    check(writes, 32'h3);
    check({12'h0, last_wr}, 32'h000FFF01);
    rd(OFS_WORK, 32'h2, 1'b0);
    conclude();
  end
endmodule
